// ===== core/pft_table_access.sv
// Table pointer, byte latch, holding bytes and self-timed erase/write sequencer on AHB-Lite.
`timescale 1ns/10ps
`include "pft_defines.svh"
module pft_table_access #(
  parameter int unsigned LONG_CYCLES = `PFT_LONG_TIME_NS / `PFT_CLK_PERIOD_NS
) (
  // Clock and resets.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Program memory read port, one cycle latency.
  output logic flash_rd_en,
  output logic [20:0] flash_rd_word_addr,
  input wire logic [15:0] flash_rd_data,
  // Self-timed cycle control towards the array.
  output logic nvm_erase_start,
  output logic nvm_write_start,
  output logic [15:0] nvm_erase_row,
  output logic [18:0] nvm_write_block,
  output logic [63:0] nvm_holding_data,
  output logic nvm_config_space,
  output logic core_stall
);
  import pft_pkg::*;

  localparam logic [17:0] LONG_LAST = 18'(LONG_CYCLES - 1);

  // Bus state.
  logic dp_valid_ff, nxt_dp_valid;
  logic dp_write_ff, nxt_dp_write;
  logic [5:0] dp_index_ff, nxt_dp_index;
  logic rd_ready_ff, nxt_rd_ready;
  logic [31:0] hrdata_ff, nxt_hrdata;
  // Table state.
  logic [21:0] table_pointer_ff, nxt_table_pointer;
  logic [7:0] table_byte_latch_ff, nxt_table_byte_latch;
  logic [1:0] fetch_cnt_ff, nxt_fetch_cnt;
  logic [20:0] rd_word_ff, nxt_rd_word;
  logic rd_hi_ff, nxt_rd_hi;
  logic [7:0] hold_ff [8];
  logic [7:0] nxt_hold [8];
  // Control state.
  pft_state_t state_ff, nxt_state;
  pft_unlock_t unlock_ff, nxt_unlock;
  logic [17:0] long_cnt_ff, nxt_long_cnt;
  logic go_ff, nxt_go;
  logic row_erase_ff, nxt_row_erase;
  logic mod_enable_ff, nxt_mod_enable;
  logic done_flag_ff, nxt_done_flag;
  logic erase_start_ff, nxt_erase_start;
  logic write_start_ff, nxt_write_start;
  // State kept through a bus reset, cleared only at power-on.
  logic program_space_select_ff, nxt_program_space_select;
  logic config_space_select_ff, nxt_config_space_select;
  logic interrupted_ff, nxt_interrupted;
  logic long_mark_ff, nxt_long_mark;

  logic blocked;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wbyte;
  logic op_fire;
  logic op_store;
  pft_mode_t op_mode;
  logic [20:0] ptr_inc;
  logic [20:0] ptr_dec;
  logic [21:0] access_addr;
  logic go_request;
  logic go_accept;
  logic long_last;
  logic [7:0] ctrl_view;

  // The core is held off from every register while a long cycle or a fetch runs.
  assign blocked = (state_ff != PFT_IDLE) || (fetch_cnt_ff != 2'b00);
  assign wr_fire = dp_valid_ff && dp_write_ff && !blocked;
  assign rd_fire = dp_valid_ff && !dp_write_ff && !blocked && !rd_ready_ff;
  assign wbyte = hwdata[7:0];
  assign hreadyout = !dp_valid_ff || (dp_write_ff ? !blocked : rd_ready_ff);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  assign ctrl_view = {program_space_select_ff, config_space_select_ff, 1'b0, row_erase_ff,
                      interrupted_ff, mod_enable_ff, go_ff, 1'b0};

  // Bus address and data phases.
  always_comb begin
    nxt_dp_valid = dp_valid_ff;
    nxt_dp_write = dp_write_ff;
    nxt_dp_index = dp_index_ff;
    nxt_rd_ready = 1'b0;
    nxt_hrdata = hrdata_ff;
    if (hreadyout) begin
      nxt_dp_valid = 1'b0;
    end
    if (hsel && htrans[1] && hready) begin
      nxt_dp_valid = 1'b1;
      nxt_dp_write = hwrite;
      nxt_dp_index = haddr[7:2];
    end
    if (rd_fire) begin
      nxt_rd_ready = 1'b1;
      case (dp_index_ff)
        `PFT_OFS_PTR_LOW: nxt_hrdata = {24'h000000, table_pointer_ff[7:0]};
        `PFT_OFS_PTR_HIGH: nxt_hrdata = {24'h000000, table_pointer_ff[15:8]};
        `PFT_OFS_PTR_UPPER: nxt_hrdata = {26'h0000000, table_pointer_ff[21:16]};
        `PFT_OFS_LATCH: nxt_hrdata = {24'h000000, table_byte_latch_ff};
        `PFT_OFS_CTRL: nxt_hrdata = {24'h000000, ctrl_view};
        `PFT_OFS_STATUS: nxt_hrdata = {30'h00000000, (state_ff != PFT_IDLE), done_flag_ff};
        default: nxt_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_index_ff <= 6'h00;
      rd_ready_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
    end else begin
      dp_valid_ff <= nxt_dp_valid;
      dp_write_ff <= nxt_dp_write;
      dp_index_ff <= nxt_dp_index;
      rd_ready_ff <= nxt_rd_ready;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // Table operations: a write to the op register is one fetch or one store.
  assign op_fire = wr_fire && (dp_index_ff == `PFT_OFS_TABLE_OP);
  assign op_store = wbyte[`PFT_OP_STORE];
  assign op_mode = pft_mode_t'(wbyte[1:0]);
  assign ptr_inc = table_pointer_ff[20:0] + 21'h000001;
  assign ptr_dec = table_pointer_ff[20:0] - 21'h000001;
  assign access_addr = (op_mode == PFT_MODE_PRE_INC) ?
                       {table_pointer_ff[21], ptr_inc} : table_pointer_ff;

  always_comb begin
    nxt_table_pointer = table_pointer_ff;
    nxt_table_byte_latch = table_byte_latch_ff;
    nxt_fetch_cnt = 2'b00;
    nxt_rd_word = rd_word_ff;
    nxt_rd_hi = rd_hi_ff;
    if (wr_fire && dp_index_ff == `PFT_OFS_PTR_LOW) begin
      nxt_table_pointer[7:0] = wbyte;
    end
    if (wr_fire && dp_index_ff == `PFT_OFS_PTR_HIGH) begin
      nxt_table_pointer[15:8] = wbyte;
    end
    if (wr_fire && dp_index_ff == `PFT_OFS_PTR_UPPER) begin
      nxt_table_pointer[21:16] = wbyte[5:0];
    end
    if (wr_fire && dp_index_ff == `PFT_OFS_LATCH) begin
      nxt_table_byte_latch = wbyte;
    end
    if (op_fire) begin
      // Only the low 21 bits move; the space select bit stays put.
      case (op_mode)
        PFT_MODE_POST_INC: nxt_table_pointer[20:0] = ptr_inc;
        PFT_MODE_POST_DEC: nxt_table_pointer[20:0] = ptr_dec;
        PFT_MODE_PRE_INC: nxt_table_pointer[20:0] = ptr_inc;
        default: nxt_table_pointer = table_pointer_ff;
      endcase
      if (!op_store) begin
        nxt_fetch_cnt = 2'b01;
        nxt_rd_word = {access_addr[21], access_addr[20:1]};
        nxt_rd_hi = access_addr[0];
      end
    end
    if (fetch_cnt_ff == 2'b01) begin
      nxt_fetch_cnt = 2'b10;
    end
    if (fetch_cnt_ff == 2'b10) begin
      nxt_table_byte_latch = rd_hi_ff ? flash_rd_data[15:8] : flash_rd_data[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      table_pointer_ff <= `PFT_PTR_RESET;
      table_byte_latch_ff <= `PFT_LATCH_RESET;
      fetch_cnt_ff <= 2'b00;
      rd_word_ff <= 21'h000000;
      rd_hi_ff <= 1'b0;
    end else begin
      table_pointer_ff <= nxt_table_pointer;
      table_byte_latch_ff <= nxt_table_byte_latch;
      fetch_cnt_ff <= nxt_fetch_cnt;
      rd_word_ff <= nxt_rd_word;
      rd_hi_ff <= nxt_rd_hi;
    end
  end

  assign flash_rd_en = (fetch_cnt_ff == 2'b01);
  assign flash_rd_word_addr = rd_word_ff;

  // Eight holding bytes, one per low pointer value.
  for (genvar i = 0; i < 8; i++) begin : g_hold
    always_comb begin
      nxt_hold[i] = hold_ff[i];
      if (op_fire && op_store && access_addr[2:0] == 3'(i)) begin
        nxt_hold[i] = table_byte_latch_ff;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        hold_ff[i] <= `PFT_HOLD_RESET;
      end else begin
        hold_ff[i] <= nxt_hold[i];
      end
    end

    assign nvm_holding_data[8 * i +: 8] = hold_ff[i];
  end

  // Unlock sequence, go request and the self-timed long cycle.
  assign go_request = wr_fire && (dp_index_ff == `PFT_OFS_CTRL) && wbyte[`PFT_CTRL_GO];
  // A request is honoured only with the unlock armed, the gate open and program space chosen.
  assign go_accept = go_request && (unlock_ff == PFT_UNL_ARMED) && mod_enable_ff &&
                     program_space_select_ff;
  assign long_last = (state_ff == PFT_LONG) && (long_cnt_ff == LONG_LAST);

  always_comb begin
    nxt_state = state_ff;
    nxt_unlock = unlock_ff;
    nxt_long_cnt = long_cnt_ff;
    nxt_go = go_ff;
    nxt_row_erase = row_erase_ff;
    nxt_mod_enable = mod_enable_ff;
    nxt_done_flag = done_flag_ff;
    nxt_erase_start = 1'b0;
    nxt_write_start = 1'b0;
    if (wr_fire && dp_index_ff == `PFT_OFS_UNLOCK) begin
      // Any store that breaks the 55h, AAh pair starts the hunt again.
      case (unlock_ff)
        PFT_UNL_NONE: nxt_unlock = (wbyte == `PFT_UNLOCK_FIRST) ? PFT_UNL_FIRST : PFT_UNL_NONE;
        PFT_UNL_FIRST: nxt_unlock = (wbyte == `PFT_UNLOCK_SECOND) ? PFT_UNL_ARMED : PFT_UNL_NONE;
        default: nxt_unlock = (wbyte == `PFT_UNLOCK_FIRST) ? PFT_UNL_FIRST : PFT_UNL_NONE;
      endcase
    end
    if (wr_fire && dp_index_ff == `PFT_OFS_CTRL) begin
      nxt_unlock = PFT_UNL_NONE;
      nxt_row_erase = wbyte[`PFT_CTRL_ROW_ERASE];
      nxt_mod_enable = wbyte[`PFT_CTRL_MOD_ENABLE];
    end
    if (wr_fire && dp_index_ff == `PFT_OFS_STATUS && wbyte[`PFT_STAT_DONE]) begin
      nxt_done_flag = 1'b0;
    end
    case (state_ff)
      PFT_IDLE: begin
        nxt_long_cnt = 18'h00000;
        if (go_accept) begin
          nxt_go = 1'b1;
          nxt_state = PFT_LONG;
          nxt_erase_start = row_erase_ff;
          nxt_write_start = !row_erase_ff;
        end
      end
      PFT_LONG: begin
        nxt_long_cnt = long_cnt_ff + 18'h00001;
        if (long_last) begin
          nxt_state = PFT_END;
        end
      end
      PFT_END: begin
        nxt_state = PFT_IDLE;
        nxt_go = 1'b0;
        nxt_row_erase = 1'b0;
        nxt_done_flag = 1'b1;
      end
      default: nxt_state = PFT_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= PFT_IDLE;
      unlock_ff <= PFT_UNL_NONE;
      long_cnt_ff <= 18'h00000;
      go_ff <= 1'b0;
      row_erase_ff <= 1'b0;
      mod_enable_ff <= 1'b0;
      done_flag_ff <= 1'b0;
      erase_start_ff <= 1'b0;
      write_start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      unlock_ff <= nxt_unlock;
      long_cnt_ff <= nxt_long_cnt;
      go_ff <= nxt_go;
      row_erase_ff <= nxt_row_erase;
      mod_enable_ff <= nxt_mod_enable;
      done_flag_ff <= nxt_done_flag;
      erase_start_ff <= nxt_erase_start;
      write_start_ff <= nxt_write_start;
    end
  end

  // The mark survives a bus reset, so a cycle cut short is still seen after release.
  always_comb begin
    nxt_program_space_select = program_space_select_ff;
    nxt_config_space_select = config_space_select_ff;
    nxt_interrupted = interrupted_ff;
    nxt_long_mark = long_mark_ff;
    if (wr_fire && dp_index_ff == `PFT_OFS_CTRL) begin
      nxt_program_space_select = wbyte[`PFT_CTRL_PGM_SEL];
      nxt_config_space_select = wbyte[`PFT_CTRL_CFG_SEL];
      nxt_interrupted = wbyte[`PFT_CTRL_INTERRUPTED];
    end
    if (go_accept) begin
      nxt_long_mark = 1'b1;
    end
    if (state_ff == PFT_END) begin
      nxt_long_mark = 1'b0;
    end
    if (long_mark_ff && state_ff == PFT_IDLE) begin
      nxt_long_mark = 1'b0;
      nxt_interrupted = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      program_space_select_ff <= 1'b0;
      config_space_select_ff <= 1'b0;
      interrupted_ff <= 1'b0;
      long_mark_ff <= 1'b0;
    end else begin
      program_space_select_ff <= nxt_program_space_select;
      config_space_select_ff <= nxt_config_space_select;
      interrupted_ff <= nxt_interrupted;
      long_mark_ff <= nxt_long_mark;
    end
  end

  assign nvm_erase_start = erase_start_ff;
  assign nvm_write_start = write_start_ff;
  assign nvm_erase_row = table_pointer_ff[21:6];
  assign nvm_write_block = table_pointer_ff[21:3];
  assign nvm_config_space = config_space_select_ff || table_pointer_ff[21];
  assign core_stall = (state_ff != PFT_IDLE);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TOP_BIT_KEPT: assert property (op_fire |=> $stable(table_pointer_ff[21]))
    else $error("table op changed the space select bit");
  AST_POST_INC: assert property (op_fire && op_mode == PFT_MODE_POST_INC |=>
    table_pointer_ff[20:0] == $past(table_pointer_ff[20:0]) + 21'h000001)
    else $error("post-increment did not add one");
  AST_POST_DEC: assert property (op_fire && op_mode == PFT_MODE_POST_DEC |=>
    table_pointer_ff[20:0] == $past(table_pointer_ff[20:0]) - 21'h000001)
    else $error("post-decrement did not subtract one");
  AST_PLAIN: assert property (op_fire && op_mode == PFT_MODE_PLAIN |=> $stable(table_pointer_ff))
    else $error("plain form moved the pointer");
  AST_START_NEEDS_UNLOCK: assert property ($rose(core_stall) |->
    $past(unlock_ff) == PFT_UNL_ARMED && $past(mod_enable_ff))
    else $error("long cycle began without unlock");
  AST_STALL_TIME: assert property (go_accept |=> core_stall [*8])
    else $error("core stall ended too early");
  AST_END_CLEARS: assert property (long_last |=> ##1 !go_ff && !row_erase_ff && done_flag_ff)
    else $error("end of long cycle did not clear go and erase select");
  AST_ERASE_PULSE: assert property (go_accept && row_erase_ff |=>
    nvm_erase_start && !nvm_write_start ##1 !nvm_erase_start)
    else $error("row erase start was not a single pulse");
  AST_LATCH_BYTE: assert property (fetch_cnt_ff == 2'b10 |=> table_byte_latch_ff ==
    ($past(rd_hi_ff) ? $past(flash_rd_data[15:8]) : $past(flash_rd_data[7:0])))
    else $error("latch took the wrong byte");
  AST_BUS_HELD: assert property (core_stall && dp_valid_ff |-> !hreadyout)
    else $error("bus answered during a long cycle");
endmodule : pft_table_access

// ===== shared/pft_defines.svh
// Register map, field positions, reset values and timing counts of the flash table-access block.
`ifndef PFT_DEFINES_SVH
`define PFT_DEFINES_SVH

`define PFT_OFS_PTR_LOW 6'h00
`define PFT_OFS_PTR_HIGH 6'h01
`define PFT_OFS_PTR_UPPER 6'h02
`define PFT_OFS_LATCH 6'h03
`define PFT_OFS_CTRL 6'h04
`define PFT_OFS_UNLOCK 6'h05
`define PFT_OFS_TABLE_OP 6'h06
`define PFT_OFS_STATUS 6'h07

`define PFT_CTRL_PGM_SEL 7
`define PFT_CTRL_CFG_SEL 6
`define PFT_CTRL_ROW_ERASE 4
`define PFT_CTRL_INTERRUPTED 3
`define PFT_CTRL_MOD_ENABLE 2
`define PFT_CTRL_GO 1

`define PFT_OP_STORE 2
`define PFT_STAT_DONE 0
`define PFT_STAT_BUSY 1

`define PFT_UNLOCK_FIRST 8'h55
`define PFT_UNLOCK_SECOND 8'haa
`define PFT_PTR_RESET 22'h000000
`define PFT_LATCH_RESET 8'h00
`define PFT_HOLD_RESET 8'hff

`define PFT_LONG_TIME_NS 2000000
`define PFT_CLK_PERIOD_NS 8

`endif

// ===== shared/pft_pkg.sv
// Types shared by the flash table-access block.
package pft_pkg;
  typedef enum logic [1:0] {
    PFT_IDLE = 2'b00,
    PFT_LONG = 2'b01,
    PFT_END = 2'b11
  } pft_state_t;

  typedef enum logic [1:0] {
    PFT_MODE_PLAIN = 2'b00,
    PFT_MODE_POST_INC = 2'b01,
    PFT_MODE_POST_DEC = 2'b10,
    PFT_MODE_PRE_INC = 2'b11
  } pft_mode_t;

  typedef enum logic [1:0] {
    PFT_UNL_NONE = 2'b00,
    PFT_UNL_FIRST = 2'b01,
    PFT_UNL_ARMED = 2'b11
  } pft_unlock_t;
endpackage : pft_pkg

// ===== testbench/pft_flash_model.sv
// Program memory model that answers the table read port one cycle after each request.
`timescale 1ns/10ps
module pft_flash_model (
  // Clock.
  input wire logic hclk,
  // Read port.
  input wire logic flash_rd_en,
  input wire logic [20:0] flash_rd_word_addr,
  output logic [15:0] flash_rd_data
);
  // High and low bytes differ for every word the bench reads, so a wrong byte lane shows up.
  function automatic logic [15:0] word_at(input logic [20:0] a);
    return {a[7:0] ^ 8'ha5, a[15:8] ^ {a[20], a[6:0]}};
  endfunction : word_at

  initial flash_rd_data = 16'h0000;

  // Outside its valid cycle the data flips, so a latch loaded a cycle late is caught.
  always @(posedge hclk) begin
    if (flash_rd_en === 1'b1) begin
      flash_rd_data <= word_at(flash_rd_word_addr);
    end else begin
      flash_rd_data <= ~flash_rd_data;
    end
  end
endmodule : pft_flash_model

// ===== testbench/tb.sv
// Self-checking bench for the flash table-access block.
`timescale 1ns/10ps
`include "pft_defines.svh"
module tb;
  import pft_pkg::*;
  localparam int unsigned LC = 20;
  localparam logic [7:0] A_PL = {`PFT_OFS_PTR_LOW, 2'b00};
  localparam logic [7:0] A_PH = {`PFT_OFS_PTR_HIGH, 2'b00};
  localparam logic [7:0] A_PU = {`PFT_OFS_PTR_UPPER, 2'b00};
  localparam logic [7:0] A_LAT = {`PFT_OFS_LATCH, 2'b00};
  localparam logic [7:0] A_CTL = {`PFT_OFS_CTRL, 2'b00};
  localparam logic [7:0] A_UNL = {`PFT_OFS_UNLOCK, 2'b00};
  localparam logic [7:0] A_OP = {`PFT_OFS_TABLE_OP, 2'b00};
  localparam logic [7:0] A_ST = {`PFT_OFS_STATUS, 2'b00};
  localparam logic [21:0] EP = 22'h01abcd;
  typedef struct packed {
    logic [21:0] p0;
    logic [1:0] md;
    logic [21:0] p1;
    logic [21:0] acc;
  } pft_row_t;
  logic hclk, hresetn, por_n, hsel, hwrite, hreadyout, hresp, flash_rd_en;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [20:0] flash_rd_word_addr, seen_addr;
  logic [15:0] flash_rd_data, nvm_erase_row, erow, w;
  logic nvm_erase_start, nvm_write_start, nvm_config_space, core_stall;
  logic [18:0] nvm_write_block, wblk;
  logic [63:0] nvm_holding_data, hold_exp;
  logic [21:0] p;
  int n_mismatch = 0, comparisons = 0, n_erase = 0, n_write = 0, n_stall = 0;
  int be, bw, bs;
  pft_row_t rows [7] = '{
    '{22'h000123, PFT_MODE_PLAIN, 22'h000123, 22'h000123},
    '{22'h000124, PFT_MODE_POST_INC, 22'h000125, 22'h000124},
    '{22'h000124, PFT_MODE_POST_DEC, 22'h000123, 22'h000124},
    '{22'h000124, PFT_MODE_PRE_INC, 22'h000125, 22'h000125},
    '{22'h3fffff, PFT_MODE_POST_INC, 22'h200000, 22'h3fffff},
    '{22'h200000, PFT_MODE_POST_DEC, 22'h3fffff, 22'h200000},
    '{22'h1fffff, PFT_MODE_PRE_INC, 22'h000000, 22'h000000}};

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  pft_table_access #(.LONG_CYCLES(LC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_rd_en(flash_rd_en),
    .flash_rd_word_addr(flash_rd_word_addr), .flash_rd_data(flash_rd_data),
    .nvm_erase_start(nvm_erase_start), .nvm_write_start(nvm_write_start),
    .nvm_erase_row(nvm_erase_row), .nvm_write_block(nvm_write_block),
    .nvm_holding_data(nvm_holding_data), .nvm_config_space(nvm_config_space),
    .core_stall(core_stall)
  );

  pft_flash_model mem (
    .hclk(hclk), .flash_rd_en(flash_rd_en), .flash_rd_word_addr(flash_rd_word_addr),
    .flash_rd_data(flash_rd_data)
  );

  // Counters are only ever compared as differences, so the bench never resets them.
  always @(posedge hclk) begin
    if (flash_rd_en === 1'b1) seen_addr <= flash_rd_word_addr;
    if (nvm_erase_start === 1'b1) begin
      n_erase <= n_erase + 1;
      erow <= nvm_erase_row;
    end
    if (nvm_write_start === 1'b1) begin
      n_write <= n_write + 1;
      wblk <= nvm_write_block;
    end
    if (core_stall === 1'b1) n_stall <= n_stall + 1;
  end

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  // Ready is sampled at the falling edge, half a cycle before the rising edge, where it has settled.
  task automatic wait_rdy(output logic [31:0] rv);
    int n;
    logic r;
    n = 0;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      rv = hrdata;
      @(posedge hclk);
      n++;
      if (n > 200) begin
        n_mismatch++;
        $display("BAD %0t bus wait ran out", $time);
        tally_and_finish();
      end
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    wait_rdy(rv);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy(rv);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h00000000, v);
  endtask : rd

  task automatic set_ptr(input logic [21:0] v);
    wr(A_PL, {24'h000000, v[7:0]});
    wr(A_PH, {24'h000000, v[15:8]});
    wr(A_PU, {26'h0000000, v[21:16]});
  endtask : set_ptr

  task automatic get_ptr(output logic [21:0] v);
    logic [31:0] a, b, c;
    rd(A_PL, a);
    rd(A_PH, b);
    rd(A_PU, c);
    v = {c[5:0], b[7:0], a[7:0]};
  endtask : get_ptr

  task automatic unlock_go(input logic [7:0] c);
    wr(A_CTL, {24'h000000, c});
    wr(A_UNL, 32'h00000055);
    wr(A_UNL, 32'h000000aa);
    wr(A_CTL, {24'h000000, c | 8'h02});
  endtask : unlock_go

  initial begin
    hresetn = 1'b0;
    por_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge hclk);
    get_ptr(p);
    check(p, `PFT_PTR_RESET);
    rd(A_LAT, d);
    check(d, `PFT_LATCH_RESET);
    check(nvm_holding_data, {8{`PFT_HOLD_RESET}});
    check(core_stall, 1'b0);
    check(hresp, 1'b0);
    rd(8'h20, d);
    check(d, 32'h00000000);
    foreach (rows[i]) begin
      set_ptr(rows[i].p0);
      wr(A_OP, {30'h00000000, rows[i].md});
      rd(A_LAT, d);
      w = mem.word_at(rows[i].acc[21:1]);
      check(d, rows[i].acc[0] ? w[15:8] : w[7:0]);
      check(seen_addr, rows[i].acc[21:1]);
      get_ptr(p);
      check(p, rows[i].p1);
      check(nvm_config_space, rows[i].p1[21]);
    end
    // Stores start at index 5 so the holding index wraps inside the block.
    set_ptr(22'h000105);
    hold_exp = {8{8'hff}};
    for (int i = 0; i < 8; i++) begin
      wr(A_LAT, 32'h00000010 + i);
      wr(A_OP, 32'h00000005);
      hold_exp[8 * ((5 + i) % 8) +: 8] = 8'h10 + 8'(i);
    end
    // The last store lands on the edge that ends the bus call, so let it settle first.
    @(posedge hclk);
    check(nvm_holding_data, hold_exp);
    get_ptr(p);
    check(p, 22'h00010d);
    bw = n_write;
    unlock_go(8'h84);
    rd(A_CTL, d);
    check(n_write - bw, 1);
    check(wblk, 19'h00021);
    wr(A_ST, 32'h00000001);
    set_ptr(EP);
    be = n_erase;
    bs = n_stall;
    unlock_go(8'h94);
    rd(A_CTL, d);
    check(d[7:0], 8'h84);
    check(n_erase - be, 1);
    check(erow, EP[21:6]);
    check(n_stall - bs, LC + 1);
    rd(A_ST, d);
    check(d[1:0], 2'b01);
    wr(A_ST, 32'h00000001);
    rd(A_ST, d);
    check(d[1:0], 2'b00);
    be = n_erase;
    bw = n_write;
    wr(A_CTL, 32'h00000094);
    wr(A_UNL, 32'h00000055);
    wr(A_UNL, 32'h00000000);
    wr(A_UNL, 32'h000000aa);
    wr(A_CTL, 32'h00000096);
    rd(A_CTL, d);
    check(d[1], 1'b0);
    unlock_go(8'h90);
    rd(A_CTL, d);
    check(d[1], 1'b0);
    check((n_erase - be) + (n_write - bw), 0);
    unlock_go(8'h94);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A_CTL, d);
    check(d[7:0], 8'h88);
    check(core_stall, 1'b0);
    wr(A_CTL, 32'h00000040);
    @(posedge hclk);
    check(nvm_config_space, 1'b1);
    tally_and_finish();
  end
endmodule : tb
